// [design/dual_timer_pkg.sv]
// Shared constants for the dual 8-bit timer status and control block
package dual_timer_pkg;
  // Bus and counter widths and the number of timers
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_TIMERS = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STAT_LO = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT_HI = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_MODE_LO = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_MODE_HI = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_SHARED = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI = 3'h6;
  // Status/control register bit positions
  localparam int B_RUN = 7;
  localparam int B_SUSP = 6;
  localparam int B_IRQ_EN = 5;
  localparam int B_MEAS = 4;
  localparam int B_FULL = 3;
  localparam int B_OVF = 2;
  localparam int B_START_LVL = 1;
  localparam int B_OUT_EN = 0;
  // Mode register fields
  localparam int B_OVF_IRQ_EN = 7;
  localparam int F_CLK_SEL_HI = 6;
  localparam int F_CLK_SEL_LO = 4;
  localparam int F_MODE_HI = 3;
  localparam int F_MODE_LO = 0;
  // Shared register fields
  localparam int B_CHAIN = 7;
  localparam int F_FILT_HI = 3;
  localparam int F_FILT_LO = 0;
  // Reset values
  localparam logic [DATA_W-1:0] RST_REG = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_ZERO = 8'h00;
  // Operating mode codes
  localparam logic [3:0] M_ONE_SHOT = 4'h0;
  localparam logic [3:0] M_CONT = 4'h1;
  localparam logic [3:0] M_FREE = 4'h2;
  localparam logic [3:0] M_PWM_FIX = 4'h3;
  localparam logic [3:0] M_PWM_VAR = 4'h4;
  localparam logic [3:0] M_PW_HIGH = 4'h5;
  localparam logic [3:0] M_PW_LOW = 4'h6;
  localparam logic [3:0] M_PW_CYC_R = 4'h7;
  localparam logic [3:0] M_PW_CYC_F = 4'h8;
  localparam logic [3:0] M_PW_HCYC = 4'h9;
  localparam logic [3:0] M_CAP_RISE = 4'ha;
  localparam logic [3:0] M_CAP_FALL = 4'hb;
  localparam logic [3:0] M_CAP_CLR_R = 4'hd;
  localparam logic [3:0] M_CAP_CLR_F = 4'he;
  // Pulse measurement sequencer
  typedef enum logic {PULSE_IDLE, PULSE_MEASURE} pulse_state_t;
endpackage : dual_timer_pkg

// [design/timer_core_if.sv]
// Carrier between the control logic and one counter core
`timescale 1ns/10ps
interface timer_core_if #(
  parameter int W = 8
);
  logic inc;
  logic clr;
  logic [W-1:0] count;
  logic carry;
  modport core (input inc, input clr, output count, output carry);
  modport ctrl (output inc, output clr, input count, input carry);
endinterface : timer_core_if

// [design/timer_count_core.sv]
// Up counter for one timer, with clear and carry out
`timescale 1ns/10ps
module timer_count_core #(
  parameter int W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  timer_core_if.core cif
);
  logic [W-1:0] count;

  // Clear has priority so a stop always lands on zero
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      count <= '0;
    end else if (cif.clr) begin
      count <= '0;
    end else if (cif.inc) begin
      count <= count + 1'b1;
    end
  end

  // Carry while stepping past the top value
  assign cif.carry = cif.inc & (&count);
  assign cif.count = count;
endmodule : timer_count_core

// [design/dual_timer_status_control.sv]
// Status and control logic for a pair of chainable 8-bit timers
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module dual_timer_status_control
  import dual_timer_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_rmw,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic [NUM_TIMERS-1:0] i_timer_in,
  input wire logic [NUM_TIMERS-1:0] i_port_out,
  input wire logic [NUM_TIMERS-1:0] i_port_drive_n,
  output logic [NUM_TIMERS-1:0] o_timer_pin,
  output logic [NUM_TIMERS-1:0] o_timer_pin_oe_n,
  output logic [NUM_TIMERS-1:0] o_irq,
  output logic [2:0] o_clk_sel_lo,
  output logic [2:0] o_clk_sel_hi,
  output logic [3:0] o_filter_sel
);
  // Software-visible state
  logic [NUM_TIMERS-1:0] run, susp, irq_en, meas, full, ovf, start_lvl;
  logic [NUM_TIMERS-1:0] out_en;
  logic [DATA_W-1:0] mode_reg [NUM_TIMERS];
  logic [DATA_W-1:0] data [NUM_TIMERS];
  logic [DATA_W-1:0] shared_reg;
  logic [NUM_TIMERS-1:0] next_run, next_susp;
  // Derived control
  logic chain, pair_link;
  logic [3:0] mode [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] is_intv, is_pwmv, is_pwmf, is_pulse, is_cap;
  logic [NUM_TIMERS-1:0] wr_stat, wr_mode, rd_data;
  logic [NUM_TIMERS-1:0] run_eff, susp_eff, live, run_prev, run_rise;
  // Pins and events
  logic [NUM_TIMERS-1:0] in_meta, in_sync, in_prev, rise, fall;
  logic [NUM_TIMERS-1:0] ev_match, ev_carry, ev_meas, xfer, force_xfer;
  logic [NUM_TIMERS-1:0] ev_ovf, restart, p_start, p_end, p_hend, cyclic;
  logic [NUM_TIMERS-1:0] cap_edge, cap_clr, cnt_go, eq, out_lvl;
  pulse_state_t pulse_st [NUM_TIMERS];
  // Counter cores
  logic [NUM_TIMERS-1:0] core_inc, core_clr, core_carry;
  logic [DATA_W-1:0] core_cnt [NUM_TIMERS];

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_core
      timer_core_if #(.W(DATA_W)) cif ();
      assign cif.inc = core_inc[g];
      assign cif.clr = core_clr[g];
      assign core_cnt[g] = cif.count;
      assign core_carry[g] = cif.carry;
      timer_count_core #(.W(DATA_W)) u_core (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .cif(cif)
      );
    end
  endgenerate

  // Mode decoding and access strobes
  assign chain = shared_reg[B_CHAIN];
  assign pair_link = chain | (|is_pwmv);
  assign o_clk_sel_lo = mode_reg[0][F_CLK_SEL_HI:F_CLK_SEL_LO];
  assign o_clk_sel_hi = mode_reg[1][F_CLK_SEL_HI:F_CLK_SEL_LO];
  assign o_filter_sel = shared_reg[F_FILT_HI:F_FILT_LO];
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      mode[i] = mode_reg[i][F_MODE_HI:F_MODE_LO];
      is_intv[i] = (mode[i] == M_ONE_SHOT) | (mode[i] == M_CONT);
      is_pwmf[i] = mode[i] == M_PWM_FIX;
      is_pwmv[i] = mode[i] == M_PWM_VAR;
      is_pulse[i] = (mode[i] >= M_PW_HIGH) & (mode[i] <= M_PW_HCYC);
      is_cap[i] = mode[i] >= M_CAP_RISE;
    end
    wr_stat[0] = i_wr_en & (i_addr == OFS_STAT_LO);
    wr_stat[1] = i_wr_en & (i_addr == OFS_STAT_HI);
    wr_mode[0] = i_wr_en & (i_addr == OFS_MODE_LO);
    wr_mode[1] = i_wr_en & (i_addr == OFS_MODE_HI);
    rd_data[0] = i_rd_en & (i_addr == OFS_DATA_LO);
    rd_data[1] = i_rd_en & (i_addr == OFS_DATA_HI);
  end

  // Chained upper timer follows the lower run and suspend
  assign run_eff = {chain ? run[0] : run[1], run[0]};
  assign susp_eff = {chain ? susp[0] : susp[1], susp[0]};
  assign live = run_eff & ~susp_eff;
  assign run_rise = run_eff & ~run_prev;

  // Input pins: two flops, then one more for edge detection
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      in_meta <= '0;
      in_sync <= '0;
      in_prev <= '0;
      run_prev <= '0;
    end else begin
      in_meta <= i_timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
      run_prev <= run_eff;
    end
  end
  assign rise = in_sync & ~in_prev;
  assign fall = ~in_sync & in_prev;

  // Edge roles per pulse width and capture variant
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      p_start[i] = 1'b0;
      p_end[i] = 1'b0;
      p_hend[i] = 1'b0;
      cyclic[i] = 1'b0;
      case (mode[i])
        M_PW_HIGH: begin
          p_start[i] = rise[i];
          p_end[i] = fall[i];
        end
        M_PW_LOW: begin
          p_start[i] = fall[i];
          p_end[i] = rise[i];
        end
        M_PW_CYC_R: begin
          p_start[i] = rise[i];
          p_end[i] = rise[i];
          cyclic[i] = 1'b1;
        end
        M_PW_CYC_F: begin
          p_start[i] = fall[i];
          p_end[i] = fall[i];
          cyclic[i] = 1'b1;
        end
        M_PW_HCYC: begin
          p_start[i] = rise[i];
          p_end[i] = rise[i];
          p_hend[i] = fall[i];
          cyclic[i] = 1'b1;
        end
        default: begin
        end
      endcase
      case (mode[i])
        M_CAP_RISE, M_CAP_CLR_R: cap_edge[i] = rise[i];
        M_CAP_FALL, M_CAP_CLR_F: cap_edge[i] = fall[i];
        default: cap_edge[i] = rise[i] | fall[i];
      endcase
      cap_edge[i] = cap_edge[i] & is_cap[i] & live[i];
      cap_clr[i] = cap_edge[i] & (mode[i] >= M_CAP_CLR_R);
    end
  end

  // Pulse width sequencer: wait for start edge, then measure
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst || !run_eff[i] || !is_pulse[i]) begin
        pulse_st[i] <= PULSE_IDLE;
      end else begin
        case (pulse_st[i])
          PULSE_IDLE: begin
            if (live[i] && p_start[i]) begin
              pulse_st[i] <= PULSE_MEASURE;
            end
          end
          PULSE_MEASURE: begin
            if (live[i] && p_end[i] && !cyclic[i]) begin
              pulse_st[i] <= PULSE_IDLE;
            end
          end
          default: pulse_st[i] <= PULSE_IDLE;
        endcase
      end
    end
  end

  // Counting, matching and measurement events
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      cnt_go[i] = live[i] & (!is_pulse[i] | (pulse_st[i] == PULSE_MEASURE));
      eq[i] = core_cnt[i] == data[i];
    end
    // Chained match compares all sixteen bits
    ev_match[0] = cnt_go[0] & eq[0] & (!chain | eq[1]);
    ev_match[1] = cnt_go[1] & eq[1] & !chain;
    ev_carry[0] = chain ? core_carry[1] : core_carry[0];
    ev_carry[1] = core_carry[1] & !chain;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ev_meas[i] = (is_pulse[i] & live[i] & (pulse_st[i] == PULSE_MEASURE)
                    & (p_end[i] | p_hend[i])) | cap_edge[i];
      force_xfer[i] = is_pulse[i] & p_hend[i];
      xfer[i] = ev_meas[i] & (!full[i] | force_xfer[i]);
      ev_ovf[i] = ((is_intv[i] | is_pwmv[i]) & ev_match[i])
                  | ((is_pulse[i] | is_cap[i]) & ev_carry[i]);
      restart[i] = (is_pulse[i] & live[i] & p_start[i]
                    & ((pulse_st[i] == PULSE_IDLE) | cyclic[i]))
                   | cap_clr[i]
                   | ((is_intv[i] | is_pwmv[i]) & ev_match[i]);
    end
    // Stopped counters sit at zero; upper is slaved when chained
    core_clr[0] = !run_eff[0] | restart[0];
    core_inc[0] = cnt_go[0];
    core_clr[1] = chain ? core_clr[0] : (!run_eff[1] | restart[1]);
    core_inc[1] = chain ? core_carry[0] : cnt_go[1];
  end

  // Run and suspend with pair mirroring
  always_comb begin
    next_run = run;
    next_susp = susp;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (ev_match[i] && mode[i] == M_ONE_SHOT) begin
        next_run[i] = 1'b0;
      end
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (wr_stat[i]) begin
        next_run[i] = i_wr_data[B_RUN];
        next_susp[i] = i_wr_data[B_SUSP];
        if (pair_link) begin
          next_susp[1-i] = i_wr_data[B_SUSP];
        end
        if (|is_pwmv) begin
          next_run[1-i] = i_wr_data[B_RUN];
        end else if (chain && !i_wr_data[B_RUN]) begin
          next_run[1-i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      run <= '0;
      susp <= '0;
    end else begin
      run <= next_run;
      susp <= next_susp;
    end
  end

  // Plain control bits of the status registers
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst) begin
        irq_en[i] <= 1'b0;
        out_en[i] <= 1'b0;
        start_lvl[i] <= 1'b0;
      end else if (wr_stat[i]) begin
        irq_en[i] <= i_wr_data[B_IRQ_EN];
        out_en[i] <= i_wr_data[B_OUT_EN];
        // Locked while running, save the slaved upper half
        if (!run_eff[i] || (chain && i == 1)) begin
          start_lvl[i] <= i_wr_data[B_START_LVL];
        end
      end
    end
  end

  // Measure/edge flag: a set in the clearing cycle survives
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst) begin
        meas[i] <= 1'b0;
      end else if (!(is_pulse[i] | is_cap[i])) begin
        meas[i] <= 1'b0;
      end else if (chain && i == 1) begin
        meas[i] <= 1'b0;
      end else if (ev_meas[i]) begin
        meas[i] <= 1'b1;
      end else if (wr_stat[i] && !i_wr_data[B_MEAS]) begin
        meas[i] <= 1'b0;
      end
    end
  end

  // Data-full flag: set by a stored result, cleared by a data read
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst) begin
        full[i] <= 1'b0;
      end else if (chain && i == 1) begin
        full[i] <= 1'b0;
      end else if (xfer[i]) begin
        full[i] <= 1'b1;
      end else if (rd_data[i]) begin
        full[i] <= 1'b0;
      end
    end
  end

  // Reload/overflow flag
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst) begin
        ovf[i] <= 1'b0;
      end else if (chain && i == 1) begin
        ovf[i] <= 1'b0;
      end else if (wr_mode[i] && i_wr_data[F_MODE_HI:F_MODE_LO] == M_PWM_VAR
                   && !is_pwmv[i]) begin
        ovf[i] <= 1'b0;
      end else if (ev_ovf[i]) begin
        ovf[i] <= 1'b1;
      end else if (wr_stat[i] && !i_wr_data[B_OVF]) begin
        ovf[i] <= 1'b0;
      end
    end
  end

  // Mode and shared registers; meant to be set before run
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mode_reg[0] <= RST_REG;
      mode_reg[1] <= RST_REG;
      shared_reg <= RST_REG;
    end else if (wr_mode[0]) begin
      mode_reg[0] <= i_wr_data;
    end else if (wr_mode[1]) begin
      mode_reg[1] <= i_wr_data;
    end else if (i_wr_en && i_addr == OFS_SHARED) begin
      shared_reg <= i_wr_data;
    end
  end

  // Data registers: reload value from software, results from counter
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      data[0] <= COUNT_ZERO;
      data[1] <= COUNT_ZERO;
    end else begin
      if (i_wr_en && i_addr == OFS_DATA_LO) begin
        data[0] <= i_wr_data;
      end
      if (i_wr_en && i_addr == OFS_DATA_HI) begin
        data[1] <= i_wr_data;
      end
      // A result overrides a same-cycle software write
      if (xfer[0]) begin
        data[0] <= core_cnt[0];
        if (chain) begin
          data[1] <= core_cnt[1];
        end
      end
      if (xfer[1] && !chain) begin
        data[1] <= core_cnt[1];
      end
    end
  end

  // Timer output level
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (i_srst) begin
        out_lvl[i] <= 1'b0;
      end else if (run_rise[i] && !(is_pwmf[i] | is_pwmv[i] | is_cap[i])) begin
        out_lvl[i] <= start_lvl[i];
      end else if ((is_intv[i] | is_pwmv[i]) && ev_match[i]) begin
        out_lvl[i] <= ~out_lvl[i];
      end else if ((mode[i] == M_FREE || is_pwmf[i]) && ev_carry[i]) begin
        out_lvl[i] <= ~out_lvl[i];
      end
    end
  end

  // Pin mux and interrupt requests
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (out_en[i]) begin
        o_timer_pin[i] = (chain && i == 1) ? out_lvl[0] : out_lvl[i];
        o_timer_pin_oe_n[i] = 1'b0;
      end else begin
        o_timer_pin[i] = i_port_out[i];
        o_timer_pin_oe_n[i] = i_port_drive_n[i];
      end
      o_irq[i] = irq_en[i]
                 & (meas[i] | (ovf[i] & mode_reg[i][B_OVF_IRQ_EN]));
    end
  end

  // Register read, answer one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rd_data <= RST_REG;
    end else if (i_rd_en) begin
      if (i_addr == OFS_STAT_LO || i_addr == OFS_STAT_HI) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
          if (i_addr[0] == i[0]) begin
            o_rd_data <= {run[i], susp[i], irq_en[i], meas[i] | i_rmw,
                          full[i], ovf[i] | i_rmw, start_lvl[i],
                          out_en[i]};
          end
        end
      end else if (i_addr == OFS_MODE_LO) begin
        o_rd_data <= mode_reg[0];
      end else if (i_addr == OFS_MODE_HI) begin
        o_rd_data <= mode_reg[1];
      end else if (i_addr == OFS_SHARED) begin
        o_rd_data <= shared_reg;
      end else if (i_addr == OFS_DATA_LO) begin
        o_rd_data <= data[0];
      end else if (i_addr == OFS_DATA_HI) begin
        o_rd_data <= data[1];
      end else begin
        o_rd_data <= RST_REG; // Unmapped reads as zero
      end
    end
  end
endmodule : dual_timer_status_control

// [tb/dual_timer_props.sv]
// Assertion checker for the dual timer status and control block
`timescale 1ns/10ps
module dual_timer_props
  import dual_timer_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_rmw,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic [NUM_TIMERS-1:0] i_port_out,
  input wire logic [NUM_TIMERS-1:0] i_port_drive_n,
  input wire logic [NUM_TIMERS-1:0] o_timer_pin,
  input wire logic [NUM_TIMERS-1:0] o_timer_pin_oe_n,
  input wire logic [NUM_TIMERS-1:0] o_irq,
  input wire logic [2:0] o_clk_sel_lo,
  input wire logic [3:0] o_filter_sel
);
  logic [1:0] oe_sh;
  logic [1:0] ie_sh;
  logic [7:0] last_wd;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Shadow of the plain read/write status bits, no side effects on them
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      oe_sh <= 2'h0;
      ie_sh <= 2'h0;
    end else if (i_wr_en && i_addr < 3'h2) begin
      oe_sh[i_addr[0]] <= i_wr_data[B_OUT_EN];
      ie_sh[i_addr[0]] <= i_wr_data[B_IRQ_EN];
    end
  end
  // Last write data, for field checks one cycle on
  always_ff @(posedge i_sys_clk) begin
    last_wd <= i_wr_data;
  end
  sequence s_pwm_sel;
    i_wr_en && i_addr == OFS_MODE_LO && i_wr_data[3:0] == M_PWM_VAR;
  endsequence
  sequence s_stat_rd;
    i_rd_en && i_addr == OFS_STAT_LO && !i_rmw;
  endsequence
  a_pwm_ovf_clr: assert property (s_pwm_sel ##[1:2] s_stat_rd |=> !o_rd_data[B_OVF])
    else $error("ovf flag seen after pwm select");
  a_rmw_ones: assert property (i_rd_en && i_rmw && i_addr < 3'h2 |=> o_rd_data[B_MEAS] && o_rd_data[B_OVF])
    else $error("rmw read did not return ones");
  a_unmapped_rd: assert property (i_rd_en && i_addr == 3'h7 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
    else $error("read data moved without strobe");
  a_stat_readback: assert property (s_stat_rd |=> o_rd_data[B_OUT_EN] == $past(oe_sh[0]) && o_rd_data[B_IRQ_EN] == $past(ie_sh[0]))
    else $error("status readback wrong");
  a_oe_drive: assert property (oe_sh[0] |-> !o_timer_pin_oe_n[0])
    else $error("pin not driven with output enabled");
  a_port_pass: assert property (!oe_sh[0] |-> o_timer_pin_oe_n[0] == i_port_drive_n[0] && o_timer_pin[0] == i_port_out[0])
    else $error("port not passed through");
  a_irq_masked: assert property ((o_irq & ~ie_sh) == 2'h0)
    else $error("irq without enable");
  a_clk_sel: assert property (i_wr_en && i_addr == OFS_MODE_LO |=> o_clk_sel_lo == last_wd[6:4])
    else $error("clock select field wrong");
  a_filter_sel: assert property (i_wr_en && i_addr == OFS_SHARED |=> o_filter_sel == last_wd[3:0])
    else $error("filter select field wrong");
endmodule : dual_timer_props

// [tb/timer_pin_partner.sv]
// External pin model driving the timer input pins
`timescale 1ns/10ps
module timer_pin_partner (
  input wire logic i_sys_clk,
  output logic [1:0] o_pin_in
);
  // Pins rest low between pulses
  initial o_pin_in = 2'h0;
  // One high pulse, edges just after a clock edge
  task automatic pulse(input int idx, input int width);
    @(posedge i_sys_clk);
    o_pin_in[idx] <= 1'b1;
    repeat (width) @(posedge i_sys_clk);
    o_pin_in[idx] <= 1'b0;
  endtask : pulse
endmodule : timer_pin_partner

// [tb/testbench.sv]
// Self-checking testbench for the dual timer status and control block
`timescale 1ns/10ps
module testbench;
  import dual_timer_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_rmw = 1'b0;
  logic [1:0] i_port_out = 2'h1;
  logic [1:0] i_port_drive_n = 2'h1;
  logic [1:0] i_timer_in;
  logic [7:0] o_rd_data;
  logic [1:0] o_timer_pin;
  logic [1:0] o_timer_pin_oe_n;
  logic [1:0] o_irq;
  logic [2:0] o_clk_sel_lo;
  logic [2:0] o_clk_sel_hi;
  logic [3:0] o_filter_sel;
  logic [7:0] d;
  int err_count = 0;
  int comparisons = 0;
  // 50 MHz clock
  always #10 i_sys_clk = ~i_sys_clk;
  dual_timer_status_control dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_rmw(i_rmw), .o_rd_data(o_rd_data),
    .i_timer_in(i_timer_in), .i_port_out(i_port_out),
    .i_port_drive_n(i_port_drive_n), .o_timer_pin(o_timer_pin),
    .o_timer_pin_oe_n(o_timer_pin_oe_n), .o_irq(o_irq),
    .o_clk_sel_lo(o_clk_sel_lo), .o_clk_sel_hi(o_clk_sel_hi),
    .o_filter_sel(o_filter_sel));
  timer_pin_partner u_pins (.i_sys_clk(i_sys_clk), .o_pin_in(i_timer_in));
  task automatic cmp_reg(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_pin
  // One-cycle write strobe; ends settled so pins can be looked at
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
    #1;
  endtask : wr
  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [2:0] a, input logic m, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    i_rmw <= m;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    i_rmw <= 1'b0;
    #1 v = o_rd_data;
  endtask : rd
  task automatic chk(input logic [2:0] a, input logic [7:0] mask,
                     input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, 1'b0, v);
    cmp_reg(what, exp, v & mask);
  endtask : chk
  // Bounded wait for the lower interrupt
  task automatic wait_irq(input int lim);
    for (int k = 0; k < lim && o_irq[0] !== 1'b1; k++) @(posedge i_sys_clk);
    #1;
  endtask : wait_irq
  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      chk(a[2:0], 8'hff, 8'h00, "reset read");
    end
    cmp_pin("pin port", 1'b1, o_timer_pin[0]);
    cmp_pin("oe port", 1'b1, o_timer_pin_oe_n[0]);
    // Setup before run; start level only lands on run rising
    wr(OFS_MODE_LO, 8'h51);
    wr(OFS_SHARED, 8'h0a);
    wr(OFS_DATA_LO, 8'hff);
    wr(OFS_STAT_LO, 8'h03);
    cmp_pin("pin idle", 1'b0, o_timer_pin[0]);
    cmp_pin("oe on", 1'b0, o_timer_pin_oe_n[0]);
    cmp_reg("clk sel", 8'h05, {5'h00, o_clk_sel_lo});
    cmp_reg("filter", 8'h0a, {4'h0, o_filter_sel});
    wr(OFS_STAT_LO, 8'h83);
    // Start level reaches the output one edge after run lands
    @(posedge i_sys_clk);
    #1;
    cmp_pin("pin start", 1'b1, o_timer_pin[0]);
    wr(OFS_STAT_LO, 8'h81);
    chk(OFS_STAT_LO, 8'h02, 8'h02, "start lock");
    wr(OFS_STAT_LO, 8'h00);
    // Suspend freezes the count, clearing it resumes
    wr(OFS_DATA_LO, 8'h20);
    wr(OFS_MODE_LO, 8'h81);
    wr(OFS_STAT_LO, 8'h80);
    wr(OFS_STAT_LO, 8'hc0);
    repeat (40) @(posedge i_sys_clk);
    chk(OFS_STAT_LO, 8'h04, 8'h00, "frozen");
    wr(OFS_STAT_LO, 8'ha0);
    wait_irq(60);
    cmp_pin("resumed irq", 1'b1, o_irq[0]);
    wr(OFS_STAT_LO, 8'h24);
    chk(OFS_STAT_LO, 8'hff, 8'h24, "ovf hold");
    wr(OFS_MODE_LO, 8'h04);
    chk(OFS_STAT_LO, 8'h04, 8'h00, "ovf pwm sel");
    // Variable PWM mirrors run and suspend across the pair
    wr(OFS_MODE_HI, 8'h04);
    wr(OFS_STAT_LO, 8'hc0);
    chk(OFS_STAT_HI, 8'hc0, 8'hc0, "mirror set");
    wr(OFS_STAT_HI, 8'h00);
    chk(OFS_STAT_LO, 8'hc0, 8'h00, "mirror clr");
    // High pulse width; second result is dropped while full
    wr(OFS_MODE_LO, 8'h05);
    wr(OFS_STAT_LO, 8'ha0);
    u_pins.pulse(0, 10);
    repeat (6) @(posedge i_sys_clk);
    #1;
    cmp_pin("meas irq", 1'b1, o_irq[0]);
    u_pins.pulse(0, 30);
    repeat (6) @(posedge i_sys_clk);
    chk(OFS_STAT_LO, 8'h18, 8'h18, "flags set");
    rd(OFS_DATA_LO, 1'b0, d);
    cmp_reg("first kept", 8'h01, {7'h00, d > 8'h05 && d < 8'h14});
    chk(OFS_STAT_LO, 8'h08, 8'h00, "full clr");
    wr(OFS_STAT_LO, 8'hb8);
    chk(OFS_STAT_LO, 8'h18, 8'h10, "full ro");
    rd(OFS_STAT_LO, 1'b1, d);
    cmp_reg("rmw ones", 8'h14, d & 8'h14);
    wr(OFS_STAT_LO, 8'ha0);
    chk(OFS_STAT_LO, 8'h10, 8'h00, "meas clr");
    u_pins.pulse(0, 10);
    repeat (6) @(posedge i_sys_clk);
    wr(OFS_MODE_LO, 8'h01);
    chk(OFS_STAT_LO, 8'h10, 8'h00, "meas off");
    // Full is still set: high-and-cycle stores the high pulse anyway
    wr(OFS_MODE_LO, 8'h09);
    u_pins.pulse(0, 20);
    repeat (6) @(posedge i_sys_clk);
    rd(OFS_DATA_LO, 1'b0, d);
    cmp_reg("high kept", 8'h01, {7'h00, d > 8'h0f && d < 8'h18});
    wr(OFS_STAT_LO, 8'h00);
    cmp_pin("pin back", 1'b1, o_timer_pin[0]);
    tally_and_finish();
  end
endmodule : testbench
bind dual_timer_status_control dual_timer_props u_props (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_rmw(i_rmw), .o_rd_data(o_rd_data), .i_port_out(i_port_out),
  .i_port_drive_n(i_port_drive_n), .o_timer_pin(o_timer_pin),
  .o_timer_pin_oe_n(o_timer_pin_oe_n), .o_irq(o_irq),
  .o_clk_sel_lo(o_clk_sel_lo), .o_filter_sel(o_filter_sel));
